// ---- design/mauh_cfg.svh ----
`ifndef MAUH_CFG_SVH
`define MAUH_CFG_SVH
`define MAUH_CLK_HZ 125000000
`define MAUH_BAUD 921600
// Bit period in clock cycles, rounded to nearest
`define MAUH_BIT_CYC ((`MAUH_CLK_HZ + `MAUH_BAUD / 2) / `MAUH_BAUD)
`define MAUH_GRANT_MS 2
`define MAUH_GRANT_CYC (`MAUH_GRANT_MS * (`MAUH_CLK_HZ / 1000))
// Receive grant settle time, well inside the grant limit
`define MAUH_GRANT_SETTLE_CYC 64
`define MAUH_CTS_TX_BITS 2
`define MAUH_EOP_RTS_BITS 1
`define MAUH_CTS_RTS_BITS 2
`define MAUH_IPG_BITS 1
`define MAUH_STROBE_US 125
`define MAUH_STROBE_CYC (`MAUH_STROBE_US * (`MAUH_CLK_HZ / 1000000))
`define MAUH_RESP_MS 100
`define MAUH_RESP_CYC (`MAUH_RESP_MS * (`MAUH_CLK_HZ / 1000))
`define MAUH_TS_RES_US 1
`define MAUH_TS_RES_CYC (`MAUH_TS_RES_US * (`MAUH_CLK_HZ / 1000000))
`define MAUH_RX_GRANT_WAIT_MS 20
`define MAUH_RX_GRANT_WAIT_CYC (`MAUH_RX_GRANT_WAIT_MS * (`MAUH_CLK_HZ / 1000))
`define MAUH_EOP_REQ_MS 1
`define MAUH_EOP_REQ_CYC (`MAUH_EOP_REQ_MS * (`MAUH_CLK_HZ / 1000))
`define MAUH_TS_BYTES 4
`endif

// ---- design/mauh_pkg.sv ----
package mauh_pkg;
   typedef logic [7:0] mauh_byte_t;
   typedef enum logic [1:0] {
      MAUH_TX_IDLE = 2'b00,
      MAUH_TX_REQ = 2'b01,
      MAUH_TX_SEND = 2'b11,
      MAUH_TX_END = 2'b10
   } mauh_tx_state_t;
endpackage

// ---- design/mauh_if.sv ----
interface mauh_if;
   logic host_send_request_n;
   logic mote_receive_grant_n;
   logic mote_send_request_n;
   logic host_receive_grant_n;
   logic timestamp_strobe_n;
   logic host_txd;
   logic mote_txd;
   modport mote (
      input host_send_request_n,
      output mote_receive_grant_n,
      output mote_send_request_n,
      input host_receive_grant_n,
      input timestamp_strobe_n,
      input host_txd,
      output mote_txd
   );
   modport host (
      output host_send_request_n,
      input mote_receive_grant_n,
      input mote_send_request_n,
      output host_receive_grant_n,
      output timestamp_strobe_n,
      output host_txd,
      input mote_txd
   );
endinterface

// ---- design/mauh_mote.sv ----
`include "mauh_cfg.svh"
module mauh_mote (
   input wire logic clk,
   input wire logic rst_n,
   mauh_if.mote link,
   input wire mauh_pkg::mauh_byte_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic tx_last,
   output mauh_pkg::mauh_byte_t rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_frame_err,
   output logic ts_busy
);
   import mauh_pkg::*;
   localparam int BIT = `MAUH_BIT_CYC;
   localparam int HALF = BIT / 2;
   localparam int SETTLE = `MAUH_GRANT_SETTLE_CYC;
   localparam int STROBE_CYC = `MAUH_STROBE_CYC;
   localparam int TSRES = `MAUH_TS_RES_CYC;
   localparam int NTS = `MAUH_TS_BYTES;

   // ***************************************************
   // Receive grant: follows request after a short settle
   // ***************************************************
   logic req_q;
   logic [31:0] gcnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_q <= 1'b0;
         gcnt_q <= '0;
         link.mote_receive_grant_n <= 1'b1;
      end else begin
         req_q <= !link.host_send_request_n;
         if ((!req_q) == link.mote_receive_grant_n) begin
            gcnt_q <= '0;
         end else if (gcnt_q >= 32'(SETTLE)) begin
            link.mote_receive_grant_n <= !req_q;
            gcnt_q <= '0;
         end else begin
            gcnt_q <= gcnt_q + 32'd1;
         end
      end
   end

   // ***************************************************
   // Receiver: mid-bit sampling, resync on each start edge
   // ***************************************************
   logic [1:0] rxs_q;
   logic rx_busy_q;
   logic [15:0] rcnt_q;
   logic [3:0] rbit_q;
   logic [8:0] rsh_q;
   logic rx_push;
   logic rx_in_ready;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxs_q <= 2'b11;
      end else begin
         rxs_q <= {rxs_q[0], link.host_txd};
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_busy_q <= 1'b0;
         rcnt_q <= '0;
         rbit_q <= '0;
         rsh_q <= '0;
         rx_frame_err <= 1'b0;
      end else begin
         rx_frame_err <= 1'b0;
         if (!rx_busy_q) begin
            if (!rxs_q[1]) begin
               rx_busy_q <= 1'b1;
               rcnt_q <= 16'(HALF);
               rbit_q <= '0;
            end
         end else if (rcnt_q == 16'(BIT - 1)) begin
            rcnt_q <= '0;
            rsh_q <= {rxs_q[1], rsh_q[8:1]};
            if (rbit_q == 4'd9) begin
               rx_busy_q <= 1'b0;
               rx_frame_err <= !rxs_q[1];
            end else begin
               rbit_q <= rbit_q + 4'd1;
            end
         end else begin
            rcnt_q <= rcnt_q + 16'd1;
         end
      end
   end
   assign rx_push = rx_busy_q && (rcnt_q == 16'(BIT - 1)) && (rbit_q == 4'd9) && rxs_q[1];

   // ***************************************************
   // Two-entry receive buffer
   // ***************************************************
   mauh_byte_t rbuf_q [2];
   logic [1:0] rcount_q;
   logic rrd_q;
   logic rwr_q;
   logic rx_pop;
   assign rx_in_ready = rcount_q != 2'd2;
   assign rx_valid = rcount_q != 2'd0;
   assign rx_data = rbuf_q[rrd_q];
   assign rx_pop = rx_valid && rx_ready;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rcount_q <= '0;
         rrd_q <= 1'b0;
         rwr_q <= 1'b0;
         rbuf_q[0] <= '0;
         rbuf_q[1] <= '0;
      end else begin
         if (rx_push && rx_in_ready) begin
            rbuf_q[rwr_q] <= rsh_q[8:1];
            rwr_q <= !rwr_q;
         end
         if (rx_pop) begin
            rrd_q <= !rrd_q;
         end
         rcount_q <= rcount_q + 2'(rx_push && rx_in_ready) - 2'(rx_pop);
      end
   end

   // ***************************************************
   // Timestamp: microsecond counter, strobe qualification
   // ***************************************************
   logic [7:0] uscnt_q;
   logic [31:0] us_q;
   logic [31:0] ts_q;
   logic [1:0] ss_q;
   logic [31:0] slow_q;
   logic ts_armed_q;
   logic ts_pend_q;
   logic [2:0] tsidx_q;
   logic ts_done;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         uscnt_q <= '0;
         us_q <= '0;
      end else if (uscnt_q == 8'(TSRES - 1)) begin
         uscnt_q <= '0;
         us_q <= us_q + 32'd1;
      end else begin
         uscnt_q <= uscnt_q + 8'd1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ss_q <= 2'b11;
         slow_q <= '0;
         ts_armed_q <= 1'b0;
         ts_pend_q <= 1'b0;
         ts_q <= '0;
      end else begin
         ss_q <= {ss_q[0], link.timestamp_strobe_n};
         if (!ss_q[1]) begin
            if (slow_q != 32'hffffffff) begin
               slow_q <= slow_q + 32'd1;
            end
            if (slow_q == 32'(STROBE_CYC - 1)) begin
               ts_armed_q <= 1'b1;
            end
         end else begin
            slow_q <= '0;
            ts_armed_q <= 1'b0;
            if (ts_armed_q && !ts_busy) begin
               ts_pend_q <= 1'b1;
               ts_q <= us_q;
            end
         end
         // Busy until the last byte of the time packet has left
         if (ts_pend_q && ts_done) begin
            ts_pend_q <= 1'b0;
         end
      end
   end
   assign ts_busy = ts_pend_q;

   // ***************************************************
   // Transmit: two-entry buffer, packet handshake, serializer
   // ***************************************************
   logic [8:0] tbuf_q [2];
   logic [1:0] tcount_q;
   logic trd_q;
   logic twr_q;
   logic t_pop;
   mauh_tx_state_t st_q;
   logic [15:0] tcnt_q;
   logic [3:0] tbit_q;
   logic [9:0] tsh_q;
   logic tbusy_q;
   logic tlast_q;
   logic ts_mode_q;
   logic [15:0] wcnt_q;
   logic byte_avail;
   logic [8:0] next_byte;
   logic tgo_q;
   assign tx_ready = tcount_q != 2'd2;
   assign ts_done = ts_mode_q && st_q == MAUH_TX_SEND && !tbusy_q && tlast_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tcount_q <= '0;
         trd_q <= 1'b0;
         twr_q <= 1'b0;
         tbuf_q[0] <= '0;
         tbuf_q[1] <= '0;
      end else begin
         if (tx_valid && tx_ready) begin
            tbuf_q[twr_q] <= {tx_last, tx_data};
            twr_q <= !twr_q;
         end
         if (t_pop) begin
            trd_q <= !trd_q;
         end
         tcount_q <= tcount_q + 2'(tx_valid && tx_ready) - 2'(t_pop);
      end
   end
   always_comb begin
      if (ts_mode_q) begin
         byte_avail = tsidx_q < 3'(NTS);
         next_byte = {tsidx_q == 3'(NTS - 1), ts_q[8 * tsidx_q[1:0] +: 8]};
      end else begin
         byte_avail = tcount_q != 2'd0;
         next_byte = tbuf_q[trd_q];
      end
   end
   assign t_pop = !ts_mode_q && st_q == MAUH_TX_SEND && !tbusy_q && byte_avail && !tlast_q &&
      (tgo_q || !link.host_receive_grant_n);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= MAUH_TX_IDLE;
         tcnt_q <= '0;
         tbit_q <= '0;
         tsh_q <= '1;
         tbusy_q <= 1'b0;
         tlast_q <= 1'b0;
         ts_mode_q <= 1'b0;
         tsidx_q <= '0;
         wcnt_q <= '0;
         tgo_q <= 1'b0;
         link.mote_send_request_n <= 1'b1;
         link.mote_txd <= 1'b1;
      end else begin
         if (tbusy_q) begin
            link.mote_txd <= tsh_q[0];
            if (tcnt_q == 16'(BIT - 1)) begin
               tcnt_q <= '0;
               tsh_q <= {1'b1, tsh_q[9:1]};
               if (tbit_q == 4'd9) begin
                  tbusy_q <= 1'b0;
               end
               tbit_q <= tbit_q + 4'd1;
            end else begin
               tcnt_q <= tcnt_q + 16'd1;
            end
         end else begin
            link.mote_txd <= 1'b1;
         end
         case (st_q)
            MAUH_TX_IDLE: begin
               if (wcnt_q != 16'd0) begin
                  wcnt_q <= wcnt_q - 16'd1;
               end else if (ts_pend_q || tcount_q != 2'd0) begin
                  ts_mode_q <= ts_pend_q;
                  tsidx_q <= '0;
                  tlast_q <= 1'b0;
                  tgo_q <= 1'b0;
                  link.mote_send_request_n <= 1'b0;
                  st_q <= MAUH_TX_REQ;
               end
            end
            MAUH_TX_REQ: begin
               if (!link.host_receive_grant_n) begin
                  st_q <= MAUH_TX_SEND;
               end
            end
            MAUH_TX_SEND: begin
               if (!tbusy_q && tlast_q) begin
                  link.mote_send_request_n <= 1'b1;
                  wcnt_q <= 16'(`MAUH_IPG_BITS * BIT);
                  ts_mode_q <= 1'b0;
                  st_q <= MAUH_TX_END;
               end else if (!tbusy_q && byte_avail && (tgo_q || !link.host_receive_grant_n)) begin
                  // Grant gates the first byte only; the rest of the packet follows
                  tsh_q <= {1'b1, next_byte[7:0], 1'b0};
                  tbusy_q <= 1'b1;
                  tgo_q <= 1'b1;
                  tcnt_q <= '0;
                  tbit_q <= '0;
                  tlast_q <= next_byte[8];
                  if (ts_mode_q) begin
                     tsidx_q <= tsidx_q + 3'd1;
                  end
               end
            end
            MAUH_TX_END: begin
               if (link.host_receive_grant_n) begin
                  st_q <= MAUH_TX_IDLE;
               end
            end
            default: st_q <= MAUH_TX_IDLE;
         endcase
      end
   end
endmodule

// ---- design/mauh_host.sv ----
`include "mauh_cfg.svh"
module mauh_host (
   input wire logic clk,
   input wire logic rst_n,
   mauh_if.host link,
   input wire mauh_pkg::mauh_byte_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic tx_last,
   output mauh_pkg::mauh_byte_t rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic ts_request
);
   import mauh_pkg::*;
   localparam int BIT = `MAUH_BIT_CYC;
   localparam int HALF = BIT / 2;

   // ***************************************************
   // Transmit to mote: request, wait grant, send bytes
   // ***************************************************
   logic [15:0] tcnt_q;
   logic [3:0] tbit_q;
   logic [9:0] tsh_q;
   logic tbusy_q;
   logic tlast_q;
   logic [31:0] gap_q;
   logic [1:0] ph_q;
   assign tx_ready = ph_q == 2'd1 && !link.mote_receive_grant_n && !tbusy_q && !tlast_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tcnt_q <= '0;
         tbit_q <= '0;
         tsh_q <= '1;
         tbusy_q <= 1'b0;
         tlast_q <= 1'b0;
         gap_q <= '0;
         ph_q <= '0;
         link.host_send_request_n <= 1'b1;
         link.host_txd <= 1'b1;
      end else begin
         link.host_txd <= tbusy_q ? tsh_q[0] : 1'b1;
         if (tbusy_q) begin
            if (tcnt_q == 16'(BIT - 1)) begin
               tcnt_q <= '0;
               tsh_q <= {1'b1, tsh_q[9:1]};
               tbusy_q <= tbit_q != 4'd9;
               tbit_q <= tbit_q + 4'd1;
            end else begin
               tcnt_q <= tcnt_q + 16'd1;
            end
         end
         case (ph_q)
            2'd0: begin
               if (gap_q != 32'd0) begin
                  gap_q <= gap_q - 32'd1;
               end else if (tx_valid) begin
                  link.host_send_request_n <= 1'b0;
                  tlast_q <= 1'b0;
                  ph_q <= 2'd1;
               end
            end
            2'd1: begin
               if (tx_valid && tx_ready) begin
                  tsh_q <= {1'b1, tx_data, 1'b0};
                  tbusy_q <= 1'b1;
                  tcnt_q <= '0;
                  tbit_q <= '0;
                  tlast_q <= tx_last;
               end else if (tlast_q && !tbusy_q) begin
                  gap_q <= 32'(`MAUH_EOP_REQ_CYC);
                  ph_q <= 2'd2;
               end
            end
            2'd2: begin
               if (gap_q != 32'd0) begin
                  gap_q <= gap_q - 32'd1;
               end else begin
                  link.host_send_request_n <= 1'b1;
                  gap_q <= 32'(`MAUH_RX_GRANT_WAIT_CYC);
                  ph_q <= 2'd0;
               end
            end
            default: ph_q <= 2'd0;
         endcase
      end
   end

   // ***************************************************
   // Receive from mote: grant the first byte while request and room
   // ***************************************************
   logic [1:0] rxs_q;
   logic rbusy_q;
   logic [15:0] rcnt_q;
   logic [3:0] rbit_q;
   logic [8:0] rsh_q;
   logic started_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxs_q <= 2'b11;
         rbusy_q <= 1'b0;
         rcnt_q <= '0;
         rbit_q <= '0;
         rsh_q <= '0;
         rx_valid <= 1'b0;
         rx_data <= '0;
         started_q <= 1'b0;
         link.host_receive_grant_n <= 1'b1;
      end else begin
         rxs_q <= {rxs_q[0], link.mote_txd};
         if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
         end
         // Grant only the first byte; drop it once its start bit is seen
         if (link.mote_send_request_n) begin
            started_q <= 1'b0;
         end else if (!rxs_q[1]) begin
            started_q <= 1'b1;
         end
         if (!link.mote_send_request_n && !started_q && !rx_valid && rxs_q[1]) begin
            link.host_receive_grant_n <= 1'b0;
         end else if (link.mote_send_request_n || !rxs_q[1]) begin
            link.host_receive_grant_n <= 1'b1;
         end
         if (!rbusy_q) begin
            if (!rxs_q[1]) begin
               rbusy_q <= 1'b1;
               rcnt_q <= 16'(HALF);
               rbit_q <= '0;
            end
         end else if (rcnt_q == 16'(BIT - 1)) begin
            rcnt_q <= '0;
            rsh_q <= {rxs_q[1], rsh_q[8:1]};
            if (rbit_q == 4'd9) begin
               rbusy_q <= 1'b0;
               rx_valid <= 1'b1;
               rx_data <= rsh_q[8:1];
            end else begin
               rbit_q <= rbit_q + 4'd1;
            end
         end else begin
            rcnt_q <= rcnt_q + 16'd1;
         end
      end
   end

   // ***************************************************
   // Timestamp strobe: low pulse for 125us
   // ***************************************************
   logic [31:0] scnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scnt_q <= '0;
         link.timestamp_strobe_n <= 1'b1;
      end else if (scnt_q != 32'd0) begin
         scnt_q <= scnt_q - 32'd1;
         if (scnt_q == 32'd1) begin
            link.timestamp_strobe_n <= 1'b1;
         end
      end else if (ts_request && link.mote_send_request_n) begin
         link.timestamp_strobe_n <= 1'b0;
         scnt_q <= 32'(`MAUH_STROBE_CYC + 1);
      end
   end
endmodule

// ---- verification/mauh_checker_assertions.sv ----
`include "mauh_cfg.svh"
module mauh_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_send_request_n,
   input wire logic mote_receive_grant_n,
   input wire logic mote_send_request_n,
   input wire logic host_receive_grant_n,
   input wire logic timestamp_strobe_n,
   input wire logic mote_txd
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = `MAUH_BIT_CYC;
   localparam int GRANT = `MAUH_GRANT_CYC;
   localparam int STROBE = `MAUH_STROBE_CYC;
   localparam int RESP = `MAUH_RESP_CYC;
   int req_w_q, rel_w_q, cts_w_q, gnt_hi_q, req_hi_q, run_q, lo_q, resp_q;
   logic sent_q, txd_q;
   // ****
   // Cycle counters
   // ****
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_w_q <= 0;
         rel_w_q <= 0;
         cts_w_q <= 0;
         gnt_hi_q <= 2 * BIT;
         req_hi_q <= BIT;
         run_q <= BIT;
         lo_q <= 0;
         resp_q <= 0;
         sent_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         req_w_q <= (!host_send_request_n && mote_receive_grant_n) ? req_w_q + 1 : 0;
         rel_w_q <= (host_send_request_n && !mote_receive_grant_n) ? rel_w_q + 1 : 0;
         sent_q <= !host_receive_grant_n && (sent_q || !mote_txd);
         cts_w_q <= (host_receive_grant_n || mote_send_request_n || sent_q) ? 0 : cts_w_q + 1;
         gnt_hi_q <= !host_receive_grant_n ? 0 : (gnt_hi_q < 2 * BIT) ? gnt_hi_q + 1 : gnt_hi_q;
         req_hi_q <= !mote_send_request_n ? 0 : (req_hi_q < BIT) ? req_hi_q + 1 : req_hi_q;
         run_q <= (mote_txd != txd_q) ? 1 : run_q + 1;
         txd_q <= mote_txd;
         lo_q <= timestamp_strobe_n ? 0 : (lo_q < STROBE) ? lo_q + 1 : lo_q;
         resp_q <= (timestamp_strobe_n && lo_q >= STROBE) ? 1 :
            (!mote_txd && txd_q) ? 0 : (resp_q != 0) ? resp_q + 1 : 0;
      end
   end
   // ****
   // Assertions
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   rx_grant_time_a: assert property (req_w_q <= GRANT)
      else $error("receive grant late after request");
   rx_release_time_a: assert property (rel_w_q <= GRANT)
      else $error("receive grant held after request dropped");
   rx_grant_cause_a: assert property ($fell(mote_receive_grant_n) |-> !host_send_request_n)
      else $error("receive grant without request");
   tx_start_time_a: assert property (cts_w_q <= 2 * BIT)
      else $error("first byte late after transmit grant");
   tx_drop_idle_a: assert property ($rose(mote_send_request_n) |-> mote_txd)
      else $error("send request dropped inside a byte");
   grant_drop_gap_a: assert property ($rose(mote_send_request_n) |-> gnt_hi_q >= 2 * BIT)
      else $error("request dropped too soon after grant");
   packet_gap_a: assert property ($fell(mote_send_request_n) |-> req_hi_q >= BIT)
      else $error("mote packets too close");
   time_reply_a: assert property (resp_q <= RESP)
      else $error("time packet late");
   bit_length_a: assert property (mote_txd != txd_q |-> run_q >= BIT - BIT / 100)
      else $error("transmit bit too short");
   low_run_a: assert property ($rose(mote_txd) |-> run_q <= 9 * BIT + 9 * BIT / 100)
      else $error("transmit low run too long");
   tx_start_cause_a: assert property ($fell(mote_txd) |-> !mote_send_request_n)
      else $error("start bit without send request");
   cover property ($fell(mote_receive_grant_n));
   cover property ($fell(mote_send_request_n));
   cover property (resp_q == 1);
endmodule

// ---- verification/mauh_test.sv ----
`include "mauh_cfg.svh"
module mauh_test;
   timeunit 1ns;
   timeprecision 1ps;
   import mauh_pkg::*;
   localparam int BIT = `MAUH_BIT_CYC;
   localparam int LIMIT = 90000;
   logic clk, rst_n;
   logic saw_full = 1'b0;
   mauh_byte_t m_tx_data, m_rx_data, h_tx_data, h_rx_data;
   logic m_tx_valid, m_tx_ready, m_tx_last, m_rx_valid, m_rx_ready, m_frame_err, m_ts_busy;
   logic h_tx_valid, h_tx_ready, h_tx_last, h_rx_valid, h_rx_ready, h_ts_request;
   logic [8:0] exp_m[$];
   logic [8:0] exp_h[$];
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   mauh_if link();
   mauh_mote u_mauh_mote (
      .clk(clk),
      .rst_n(rst_n),
      .link(link),
      .tx_data(m_tx_data),
      .tx_valid(m_tx_valid),
      .tx_ready(m_tx_ready),
      .tx_last(m_tx_last),
      .rx_data(m_rx_data),
      .rx_valid(m_rx_valid),
      .rx_ready(m_rx_ready),
      .rx_frame_err(m_frame_err),
      .ts_busy(m_ts_busy)
   );
   mauh_host u_mauh_host (
      .clk(clk),
      .rst_n(rst_n),
      .link(link),
      .tx_data(h_tx_data),
      .tx_valid(h_tx_valid),
      .tx_ready(h_tx_ready),
      .tx_last(h_tx_last),
      .rx_data(h_rx_data),
      .rx_valid(h_rx_valid),
      .rx_ready(h_rx_ready),
      .ts_request(h_ts_request)
   );
   mauh_checker u_mauh_checker (
      .clk(clk),
      .rst_n(rst_n),
      .host_send_request_n(link.host_send_request_n),
      .mote_receive_grant_n(link.mote_receive_grant_n),
      .mote_send_request_n(link.mote_send_request_n),
      .host_receive_grant_n(link.host_receive_grant_n),
      .timestamp_strobe_n(link.timestamp_strobe_n),
      .mote_txd(link.mote_txd)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ****
   // Tasks
   // ****
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Bit 8 of an expected value marks a byte whose value is not predicted
   task automatic compare(input string what, input logic [8:0] exp, input logic [7:0] seen);
      check_count++;
      if (!exp[8] && seen !== exp[7:0]) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp[7:0], seen);
      end
   endtask
   task automatic send_pkt(input bit to_mote, input int n);
      mauh_byte_t b;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         b = mauh_byte_t'($urandom);
         if (to_mote) begin
            h_tx_data = b;
            h_tx_valid = 1'b1;
            h_tx_last = (i == n - 1);
            exp_m.push_back({1'b0, b});
         end else begin
            m_tx_data = b;
            m_tx_valid = 1'b1;
            m_tx_last = (i == n - 1);
            exp_h.push_back({1'b0, b});
         end
         // Ready is settled at the falling edge; the byte is taken at the next rising edge
         while ((to_mote ? h_tx_ready : m_tx_ready) !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      @(negedge clk);
      h_tx_valid = 1'b0;
      m_tx_valid = 1'b0;
   endtask
   task automatic drain(ref logic [8:0] q[$]);
      while (q.size() != 0) @(posedge clk);
   endtask
   // ****
   // Output monitor and timeout
   // ****
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst_n && m_rx_valid === 1'b1 && m_rx_ready === 1'b1) begin
         compare("mote rx byte", exp_m.size() != 0 ? exp_m.pop_front() : {1'b0, ~m_rx_data},
            m_rx_data);
      end
      if (rst_n && h_rx_valid === 1'b1 && h_rx_ready === 1'b1) begin
         compare("host rx byte", exp_h.size() != 0 ? exp_h.pop_front() : {1'b0, ~h_rx_data},
            h_rx_data);
      end
      if (rst_n && m_frame_err !== 1'b0) begin
         compare("frame error", 9'h000, 8'h01);
      end
      if (rst_n && m_tx_valid === 1'b1 && m_tx_ready === 1'b0) begin
         saw_full <= 1'b1;
      end
      if (cyc == LIMIT) begin
         fails++;
         test_done();
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      rst_n = 1'b0;
      {m_tx_valid, m_tx_last, h_tx_valid, h_tx_last, h_ts_request} = 5'h00;
      m_tx_data = 8'h00;
      h_tx_data = 8'h00;
      m_rx_ready = 1'b0;
      h_rx_ready = 1'b1;
      void'($urandom(32'hc3e0));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      // Host packet lands in the mote buffer while its reader stalls
      send_pkt(1'b1, 2);
      @(negedge clk iff link.mote_receive_grant_n === 1'b0);
      repeat (25 * BIT) @(negedge clk);
      compare("rx buffer held", 9'h001, {7'h00, m_rx_valid});
      m_rx_ready = 1'b1;
      drain(exp_m);
      $display("test host_to_mote done");
      // Back-to-back mote packets fill the two-entry transmit buffer until it refuses bytes
      send_pkt(1'b0, 4);
      send_pkt(1'b0, 2);
      drain(exp_h);
      compare("tx buffer refusal", 9'h001, {7'h00, saw_full});
      $display("test mote_to_host done");
      // Two strobes in turn, each answered by a four-byte time packet
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         h_ts_request = 1'b1;
         // Hold the request until the host has launched its strobe
         @(negedge clk iff link.timestamp_strobe_n === 1'b0);
         h_ts_request = 1'b0;
         repeat (`MAUH_TS_BYTES) exp_h.push_back(9'h100);
         @(negedge clk iff link.timestamp_strobe_n === 1'b1);
         repeat (4) @(negedge clk);
         compare("ts busy set", 9'h001, {7'h00, m_ts_busy});
         drain(exp_h);
         @(negedge clk iff link.mote_send_request_n === 1'b1);
         compare("ts busy cleared", 9'h000, {7'h00, m_ts_busy});
      end
      $display("test timestamp done");
      test_done();
   end
endmodule
